/* File: btr_pkg.sv */
// Constants and types shared by the block transfer and read-modify-write slave
// How it works
// (R1) Master sends only the start address, then data at rising locations.
// (R2) Responding slave captures the broadcast start address into its local counter.
// (R3) Master holds address strobe low and restrobes after each acknowledge, ascending.
// (R4) Slave advances its local counter on each data strobe cycle of a block.
// (R5) Master never lets one block cross an aligned 256-byte boundary.
// (R6) Upper address decoded once at block start; only A01 to A07 counted.
// (R7) Master may raise address strobe at a boundary and start a new block.
// (R8) Bus ownership changes only while address strobe is high, never inside blocks.
// (R9) Even-and-odd byte modules handle single-byte block reads and writes.
// (R10) Sixteen-bit modules handle double-byte block reads and writes.
// (R11) Thirty-two-bit modules handle quad-byte block reads and writes.
// (R12) Read-modify-write is read then write to one location, address strobe held low.
// (R13) No ownership change between read and write halves, so test-and-set is atomic.
// (R14) Even-and-odd byte modules handle byte read-modify-write at positions 0 to 3.
// (R15) Odd-byte-only slave accepts byte read-modify-write only at positions 1 and 3.
// (R16) Sixteen-bit modules handle pair read-modify-write on bytes 0-1 and 2-3.
// (R17) Thirty-two-bit modules handle quad read-modify-write on bytes 0 to 3.
// (R18) Slave ignores any transfer while interrupt acknowledge is low.
// (R19) Block counter steps by transfer width: one, two or four bytes.
package btr_pkg;
    localparam int ADDR_HI = 31;
    localparam int WIN_LSB = 16;
    localparam int REGION_LSB = 8;
    localparam int SYNC_W = 75;
    localparam logic [1:0] AM_BLT_LOW = 2'h3;
    localparam logic [1:0] DS_IDLE = 2'h3;
    localparam logic DTACK_LEVEL = 1'b0;
    localparam logic [2:0] STEP_1 = 3'h1;
    localparam logic [2:0] STEP_2 = 3'h2;
    localparam logic [2:0] STEP_4 = 3'h4;
    localparam logic [3:0] BE_NONE = 4'h0;
    localparam logic [3:0] BE_QUAD = 4'hf;
    localparam logic [3:0] BE_PAIR_LO = 4'h3;
    localparam logic [3:0] BE_PAIR_HI = 4'hc;
    localparam logic [3:0] BE_BYTE1 = 4'h2;
    localparam logic [3:0] BE_BYTE3 = 4'h8;
    typedef enum logic [1:0] {
        BTR_D08EO = 2'h0,
        BTR_D08O = 2'h1,
        BTR_D16 = 2'h2,
        BTR_D32 = 2'h3
    } btr_cap_t;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_WAIT = 6'h02,
        ST_MEMRD = 6'h04,
        ST_DRIVE = 6'h08,
        ST_ACK = 6'h10,
        ST_SKIP = 6'h20
    } btr_state_t;
endpackage

/* File: btr_sync.sv */
// Two-stage synchroniser for bus pins
module btr_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } btr_sync_t;

    btr_sync_t r_reg;
    btr_sync_t r_next;

    always_comb
    begin
        r_next.s1 = d;
        r_next.s2 = r_reg.s1;
    end

    // Idle bus lines are high
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            r_reg <= '1;
        else
            r_reg <= r_next;
    end

    assign q = r_reg.s2;
endmodule

/* File: btr_lane.sv */
// Byte lane decode of strobes, long-word line and address bit 1
module btr_lane
    import btr_pkg::*;
(
    input wire logic ds0_n,
    input wire logic ds1_n,
    input wire logic lword_n,
    input wire logic a1,
    input wire btr_pkg::btr_cap_t cap,
    output logic [3:0] be,
    output logic [2:0] step,
    output logic [1:0] lo,
    output logic legal
);
    always_comb
    begin
        be = BE_NONE;
        step = STEP_1;
        lo = 2'h0;
        legal = 1'b0;
        if (!ds0_n && !ds1_n && !lword_n && !a1)
        begin
            be = BE_QUAD;
            step = STEP_4;
            legal = (cap == BTR_D32); // see R11 see R17
        end
        else if (!ds0_n && !ds1_n && lword_n)
        begin
            be = a1 ? BE_PAIR_HI : BE_PAIR_LO;
            step = STEP_2;
            lo = {a1, 1'b0};
            legal = (cap == BTR_D16) || (cap == BTR_D32); // see R10 see R16
        end
        else if ((ds0_n != ds1_n) && lword_n)
        begin
            lo = {a1, ds1_n};
            be = 4'(4'h1 << lo);
            // Odd-only slaves see bytes 1 and 3 only
            legal = (cap != BTR_D08O) || ds1_n; // see R9 see R14 see R15
        end
    end
endmodule

/* File: btr_slave.sv */
// Backplane slave for single, block and read-modify-write transfers
module btr_slave
    import btr_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic AS_N,
    input wire logic DS0_N,
    input wire logic DS1_N,
    input wire logic WRITE_N,
    input wire logic IACK_N,
    input wire logic LWORD_N,
    input wire logic [5:0] AM,
    input wire logic [btr_pkg::ADDR_HI:1] ADDR,
    input wire logic [31:0] D_IN,
    output logic [31:0] D_OUT,
    output logic D_OE,
    output logic DTACK_O,
    output logic DTACK_OE,
    input wire logic [btr_pkg::ADDR_HI-btr_pkg::WIN_LSB:0] SLAVE_BASE,
    input wire btr_pkg::btr_cap_t CAP,
    input wire logic BLT_EN,
    output logic MEM_REQ,
    output logic MEM_WE,
    output logic [3:0] MEM_BE,
    output logic [29:0] MEM_ADDR,
    output logic [31:0] MEM_WDATA,
    input wire logic [31:0] MEM_RDATA,
    output logic BUS_HELD
);
    import btr_pkg::*;

    typedef struct packed {
        btr_state_t st;
        logic [1:0] ds_prev;
        logic blt;
        logic [ADDR_HI-REGION_LSB:0] upper;
        logic [7:0] cnt;
        logic [7:0] badr;
        logic [2:0] step;
        logic [3:0] be;
        logic wr;
        logic req;
        logic [31:0] wdata;
        logic [31:0] dout;
        logic doe;
        logic dtack;
        logic dtack_o;
        logic held;
    } btr_slave_t;

    localparam btr_slave_t RESET_VAL = '{
        st: ST_IDLE,
        ds_prev: DS_IDLE,
        dtack_o: DTACK_LEVEL,
        default: '0
    };

    btr_slave_t r_reg;
    btr_slave_t r_next;

    logic [SYNC_W-1:0] pins;
    logic as_n;
    logic ds1_n;
    logic ds0_n;
    logic write_n;
    logic iack_n;
    logic lword_n;
    logic [5:0] am;
    logic [ADDR_HI:1] addr;
    logic [31:0] d_in;
    logic beat;
    logic ds_high;
    logic sel;
    logic [3:0] be;
    logic [2:0] step;
    logic [1:0] lo;
    logic legal;
    logic [7:0] nxt_adr;

    btr_sync #(
        .W(SYNC_W)
    ) u_sync (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .d({AS_N, DS1_N, DS0_N, WRITE_N, IACK_N, LWORD_N, AM, ADDR, D_IN}),
        .q(pins)
    );

    assign {as_n, ds1_n, ds0_n, write_n, iack_n, lword_n, am, addr, d_in} = pins;

    btr_lane u_lane (
        .ds0_n(ds0_n),
        .ds1_n(ds1_n),
        .lword_n(lword_n),
        .a1(r_reg.cnt[1]),
        .cap(CAP),
        .be(be),
        .step(step),
        .lo(lo),
        .legal(legal)
    );

    // Strobes must read the same on two samples to ride out skew
    assign beat = (!ds0_n || !ds1_n) && ({ds1_n, ds0_n} == r_reg.ds_prev);
    assign ds_high = ds0_n && ds1_n;
    assign sel = (addr[ADDR_HI:WIN_LSB] == SLAVE_BASE)
        && (BLT_EN || (am[1:0] != AM_BLT_LOW));
    assign nxt_adr = r_reg.badr + {5'h0, r_reg.step};

    // Bus data lanes to memory word lanes, byte 0 most significant
    function automatic logic [31:0] wmap(input logic [31:0] d, input logic quad);
        logic [31:0] w;
        w = d;
        if (!quad)
        begin
            for (int i = 0; i < 4; i++)
            begin
                w[31-8*i -: 8] = (i % 2 == 1) ? d[7:0] : d[15:8];
            end
        end
        return w;
    endfunction

    // Memory word lanes back onto bus data lanes
    function automatic logic [31:0] rmap(input logic [31:0] rd, input logic [3:0] bsel);
        logic [31:0] o;
        o = rd;
        if (bsel != BE_QUAD)
        begin
            o[31:16] = 16'h0000;
            o[15:8] = bsel[0] ? rd[31:24] : rd[15:8];
            o[7:0] = bsel[1] ? rd[23:16] : rd[7:0];
        end
        return o;
    endfunction

    always_comb
    begin
        r_next = r_reg;
        r_next.req = 1'b0;
        r_next.ds_prev = {ds1_n, ds0_n};
        r_next.held = !as_n; // see R8 see R13
        case (r_reg.st)
            ST_IDLE:
            begin
                if (!as_n && beat)
                begin
                    if (!iack_n)
                        r_next.st = ST_SKIP; // see R18
                    else if (!sel)
                        r_next.st = ST_SKIP;
                    else
                    begin
                        r_next.upper = addr[ADDR_HI:REGION_LSB]; // see R2 see R6
                        r_next.cnt = {addr[7:1], 1'b0}; // see R2
                        r_next.blt = (am[1:0] == AM_BLT_LOW);
                        r_next.st = ST_WAIT;
                    end
                end
            end
            ST_WAIT:
            begin
                if (as_n)
                    r_next.st = ST_IDLE;
                else if (beat)
                begin
                    if (!legal)
                        r_next.st = ST_SKIP; // see R15
                    else
                    begin
                        r_next.badr = {r_reg.cnt[7:2], lo};
                        r_next.step = step;
                        r_next.be = be;
                        r_next.wr = !write_n;
                        r_next.req = 1'b1;
                        r_next.wdata = wmap(d_in, be == BE_QUAD);
                        r_next.dtack = !write_n;
                        r_next.st = write_n ? ST_MEMRD : ST_ACK;
                    end
                end
            end
            ST_MEMRD:
            begin
                r_next.dout = rmap(MEM_RDATA, r_reg.be);
                r_next.doe = 1'b1;
                r_next.st = ST_DRIVE;
            end
            ST_DRIVE:
            begin
                r_next.dtack = 1'b1;
                r_next.st = ST_ACK;
            end
            ST_ACK:
            begin
                if (ds_high)
                begin
                    r_next.dtack = 1'b0;
                    r_next.doe = 1'b0;
                    // Read-modify-write keeps the same location
                    if (r_reg.blt)
                        r_next.cnt = nxt_adr; // see R4 see R19 see R12
                    r_next.st = as_n ? ST_IDLE : ST_WAIT; // see R3
                end
            end
            ST_SKIP:
            begin
                if (as_n)
                    r_next.st = ST_IDLE;
            end
            default:
            begin
                r_next.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
            r_reg <= RESET_VAL;
        else
            r_reg <= r_next;
    end

    assign D_OUT = r_reg.dout;
    assign D_OE = r_reg.doe;
    assign DTACK_O = r_reg.dtack_o;
    assign DTACK_OE = r_reg.dtack;
    assign MEM_REQ = r_reg.req;
    assign MEM_WE = r_reg.wr;
    assign MEM_BE = r_reg.be;
    assign MEM_ADDR = {r_reg.upper, r_reg.badr[7:2]};
    assign MEM_WDATA = r_reg.wdata;
    assign BUS_HELD = r_reg.held;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    sequence rd_req_s;
        r_reg.req && !r_reg.wr;
    endsequence

    sequence rd_drive_s;
        !r_reg.doe ##1 (r_reg.doe && !r_reg.dtack) ##1 (r_reg.doe && r_reg.dtack);
    endsequence

    iack_ignore_a: assert property ( // see R18
        (r_reg.st == ST_IDLE && !as_n && beat && !iack_n) |=> r_reg.st == ST_SKIP
    ) else $error("transfer taken with interrupt acknowledge low");

    addr_capture_a: assert property ( // see R2
        (r_reg.st == ST_IDLE && !as_n && beat && iack_n && sel)
        |=> (r_reg.upper == $past(addr[ADDR_HI:REGION_LSB])) && r_reg.st == ST_WAIT
    ) else $error("start address not captured");

    upper_stable_a: assert property ( // see R6
        (r_reg.st == ST_ACK) |=> $stable(r_reg.upper)
    ) else $error("upper address changed inside block");

    cnt_step_a: assert property ( // see R4
        (r_reg.st == ST_ACK && ds_high && r_reg.blt) |=> r_reg.cnt == $past(nxt_adr)
    ) else $error("block counter not advanced by width");

    rmw_same_a: assert property ( // see R12
        (r_reg.st == ST_ACK && ds_high && !r_reg.blt) |=> $stable(r_reg.cnt)
    ) else $error("counter moved outside a block");

    step_width_a: assert property ( // see R19
        r_reg.req |-> (r_reg.step == STEP_4) == (r_reg.be == BE_QUAD)
            && (r_reg.step == STEP_1) == $onehot(r_reg.be)
    ) else $error("step does not match transfer width");

    odd_only_a: assert property ( // see R15
        (r_reg.req && CAP == BTR_D08O) |-> (r_reg.be == BE_BYTE1 || r_reg.be == BE_BYTE3)
    ) else $error("odd-only slave took an even byte");

    quad_cap_a: assert property ( // see R11
        (r_reg.req && r_reg.be == BE_QUAD) |-> CAP == BTR_D32
    ) else $error("quad transfer without 32-bit capability");

    pair_lanes_a: assert property ( // see R16
        (r_reg.req && r_reg.step == STEP_2) |-> (r_reg.be == BE_PAIR_LO || r_reg.be == BE_PAIR_HI)
    ) else $error("double byte on wrong pair");

    held_bus_a: assert property ( // see R8
        !as_n |=> BUS_HELD
    ) else $error("ownership hold not shown while address strobe low");

    read_seq_a: assert property ( // see R13
        rd_req_s |-> rd_drive_s
    ) else $error("read data and acknowledge out of order");

    dtack_release_a: assert property ( // see R3
        (r_reg.st == ST_ACK && ds_high) |=> !DTACK_OE && !D_OE
    ) else $error("acknowledge held after strobes rose");
endmodule

/* File: btr_master.sv */
// Backplane master model for block and read-modify-write cycles
module btr_master (
    input wire logic clk,
    input wire logic dtack_oe,
    input wire logic [31:0] d_out,
    output logic as_n,
    output logic ds0_n,
    output logic ds1_n,
    output logic write_n,
    output logic iack_n,
    output logic lword_n,
    output logic [5:0] am,
    output logic [31:1] addr,
    output logic [31:0] d_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        {as_n, ds0_n, ds1_n, write_n, iack_n, lword_n} = 6'h3f;
        am = 6'h00;
        addr = '1;
        d_in = 32'h5a5a_5a5a;
    end
    // Ownership only ever taken while the strobe is high
    task automatic start(input logic [31:0] a, input logic [5:0] m, input logic ia);
        @(negedge clk);
        addr = a[31:1];
        am = m;
        iack_n = ia;
        as_n = 1'b0;
    endtask
    task automatic beat(input logic s0, s1, lw, wr, input logic [31:0] d,
        output logic ok, output logic [31:0] rd);
        int n;
        @(negedge clk);
        {ds0_n, ds1_n, lword_n, write_n} = {s0, s1, lw, wr};
        d_in = d;
        for (n = 0; n < 30 && dtack_oe !== 1'b1; n++)
            @(negedge clk);
        ok = (dtack_oe === 1'b1);
        rd = d_out;
        // Released lines show the inverse; address not resent in a block
        {ds0_n, ds1_n} = 2'h3;
        d_in = ~d;
        if (am[1:0] == 2'h3)
            addr = ~addr;
        for (n = 0; n < 30 && dtack_oe !== 1'b0; n++)
            @(negedge clk);
    endtask
    // Bench keeps blocks inside one region, ending each block with the address strobe raised
    task automatic finish();
        @(negedge clk);
        as_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask
endmodule

/* File: btr_slave_bench.sv */
// Self-checking bench for the block and read-modify-write slave
module btr_slave_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import btr_pkg::*;
    localparam logic [31:0] MRD = 32'h1122_3344;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic as_n, ds0_n, ds1_n, write_n, iack_n, lword_n, blt_en = 1'b1;
    logic [5:0] am;
    logic [31:1] addr;
    logic [31:0] d_in, d_out, mem_wdata, m_wd;
    logic d_oe, dtack_o, dtack_oe, mem_req, mem_we, bus_held, m_we;
    logic [3:0] mem_be, m_be;
    logic [29:0] mem_addr, m_addr;
    btr_cap_t cap = BTR_D32;
    int n_req = 0, cyc = 0, bad_count = 0, samples_checked = 0;
    always #50 sys_clk = ~sys_clk;
    btr_master m (.clk(sys_clk), .dtack_oe(dtack_oe), .d_out(d_out), .as_n(as_n),
        .ds0_n(ds0_n), .ds1_n(ds1_n), .write_n(write_n), .iack_n(iack_n),
        .lword_n(lword_n), .am(am), .addr(addr), .d_in(d_in));
    btr_slave DUT (.SYS_CLK(sys_clk), .RST_N(rst_n), .AS_N(as_n), .DS0_N(ds0_n),
        .DS1_N(ds1_n), .WRITE_N(write_n), .IACK_N(iack_n), .LWORD_N(lword_n), .AM(am),
        .ADDR(addr), .D_IN(d_in), .D_OUT(d_out), .D_OE(d_oe), .DTACK_O(dtack_o),
        .DTACK_OE(dtack_oe), .SLAVE_BASE(16'h00a5), .CAP(cap), .BLT_EN(blt_en),
        .MEM_REQ(mem_req), .MEM_WE(mem_we), .MEM_BE(mem_be), .MEM_ADDR(mem_addr),
        .MEM_WDATA(mem_wdata), .MEM_RDATA(MRD), .BUS_HELD(bus_held));
    // Memory side capture and run limit
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (mem_req === 1'b1)
        begin
            {m_we, m_be, m_addr, m_wd} <= {mem_we, mem_be, mem_addr, mem_wdata};
            n_req <= n_req + 1;
        end
        if (cyc == 20000)
        begin
            bad_count++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One block; kind 0 byte, 1 pair, 2 quad
    task automatic t_block(input btr_cap_t c, input logic [31:0] a, input int k, input int cnt);
        logic ok;
        logic [31:0] rd, x;
        int w;
        w = 1 << k;
        cap = c;
        m.start(a, 6'h0b, 1'b1);
        for (int i = 0; i < cnt; i++)
        begin
            x = a + w * i;
            m.beat(k == 0 ? ~x[0] : 1'b0, k == 0 ? x[0] : 1'b0, k != 2, 1'b0, x, ok, rd);
            chk("block ack", ok, 1'b1);
            chk("block addr", m_addr, x >> 2);
            chk("block be", m_be,
                k == 2 ? 4'hf : k == 1 ? (x[1] ? 4'hc : 4'h3) : 4'h1 << x[1:0]);
            chk("block ack level", dtack_o, 1'b0);
            chk("block held", bus_held, 1'b1);
            if (k == 2)
                chk("block wdata", m_wd, x);
        end
        m.finish();
        chk("block reqs", n_req, cnt);
        n_req = 0;
        $display("block test kind %0d done", k);
    endtask
    task automatic t_rmw();
        logic [5:0] tbl [11] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h10, 6'h11, 6'h12, 6'h13,
            6'h24, 6'h26, 6'h38};
        logic ok, go;
        logic [31:0] rd, ex, mk;
        logic [1:0] o, k;
        foreach (tbl[i])
        begin
            cap = btr_cap_t'(tbl[i][5:4]);
            k = tbl[i][3:2];
            o = tbl[i][1:0];
            go = !(cap == BTR_D08O && !o[0]);
            mk = k == 2 ? '1 : k == 1 ? 32'hffff : (o[0] ? 32'hff : 32'hff00);
            ex = k == 2 ? MRD : k == 1 ? (o[1] ? MRD & 32'hffff : MRD >> 16)
                : ((MRD >> (24 - 8 * o)) & 32'hff) << (o[0] ? 0 : 8);
            n_req = 0;
            m.start(32'h00a5_0100 + o, 6'h09, 1'b1);
            m.beat(k == 0 ? ~o[0] : 1'b0, k == 0 ? o[0] : 1'b0, k != 2, 1'b1, 0, ok, rd);
            chk("rmw read ack", ok, go);
            if (go)
            begin
                chk("rmw read data", rd & mk, ex);
                chk("rmw read we", m_we, 1'b0);
            end
            m.beat(k == 0 ? ~o[0] : 1'b0, k == 0 ? o[0] : 1'b0, k != 2, 1'b0, 1, ok, rd);
            chk("rmw write ack", ok, go);
            chk("rmw reqs", n_req, go ? 2 : 0);
            if (go)
            begin
                chk("rmw addr", m_addr, 32'h00a5_0100 >> 2);
                chk("rmw we", m_we, 1'b1);
                chk("rmw held", bus_held, 1'b1);
            end
            m.finish();
        end
        $display("read-modify-write test done");
    endtask
    task automatic t_refuse();
        logic ok;
        logic [31:0] rd;
        cap = BTR_D32;
        n_req = 0;
        for (int i = 0; i < 3; i++)
        begin
            blt_en = i != 1;
            m.start(i == 2 ? 32'h00a6_0000 : 32'h00a5_0000, 6'h0b, i != 0);
            m.beat(1'b0, 1'b0, 1'b0, 1'b0, 0, ok, rd);
            chk("refused ack", ok, 1'b0);
            m.finish();
        end
        chk("refused reqs", n_req, 0);
        blt_en = 1'b1;
        $display("refusal test done");
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (5) @(negedge sys_clk);
        t_block(BTR_D32, 32'h00a5_00f4, 2, 3);
        t_block(BTR_D16, 32'h00a5_0002, 1, 3);
        t_block(BTR_D08EO, 32'h00a5_00fd, 0, 3);
        t_rmw();
        t_refuse();
        stop_test();
    end
endmodule
